// [rtl/conv_ctrl_params.svh]
`ifndef CONV_CTRL_PARAMS_SVH
`define CONV_CTRL_PARAMS_SVH

// Register byte offsets
`define OFS_ADC_CONTROL 12'h000
`define OFS_ADC_FORMAT 12'h004
`define OFS_RESULT_HIGH 12'h008
`define OFS_RESULT_LOW 12'h00C
`define OFS_DAC_CONTROL_ZERO 12'h010
`define OFS_DAC_CONTROL_ONE 12'h014
`define OFS_PIN_STATUS 12'h018

// Field positions
`define BIT_CONV_GO 1
`define BIT_JUSTIFY 7
`define BIT_DAC_EN 7
`define BIT_DAC_OE 5
`define BIT_PSS_HI 3
`define BIT_PSS_LO 2

// Reset values
`define RST_ADC_CONTROL 8'h00
`define RST_ADC_FORMAT 8'h00
`define RST_DAC_ZERO 8'h00
`define RST_DAC_ONE 8'h00

// Timing: default conversion time in cycles
`define CONV_CYCLES_DEFAULT 16

`endif

// [rtl/conv_ctrl_pkg.sv]
package conv_ctrl_pkg;
  typedef enum logic [1:0] {
    src_supply,
    src_ext_ref,
    src_fixed_reference,
    src_reserved
  } dac_source_t;

  typedef enum {
    conv_idle,
    conv_busy
  } conv_state_t;
endpackage

// [rtl/result_if.sv]
`timescale 1ns/1ps
interface result_if;
  logic load;
  logic justify;
  logic [9:0] conversion_result;
  logic [7:0] high;
  logic [7:0] low;
  modport fmt (input load, input justify, input conversion_result,
    output high, output low);
  modport ctl (output load, output justify, output conversion_result,
    input high, input low);
endinterface

// [rtl/result_format.sv]
`timescale 1ns/1ps
module result_format (
  // Clock
  input wire logic pclk,
  // Result path
  result_if.fmt rif
);
  // ------------------------------
  // Result registers
  // ------------------------------
  // No reset: content survives every reset until the next load
  always_ff @(posedge pclk) begin
    if (rif.load) begin
      if (rif.justify) begin
        rif.high <= {6'h00, rif.conversion_result[9:8]}; // RULE1 RULE3
        rif.low <= rif.conversion_result[7:0]; // RULE2
      end else begin
        rif.high <= rif.conversion_result[9:2]; // RULE3
        rif.low <= {rif.conversion_result[1:0], 6'h00}; // RULE3
      end
    end
  end // RULE15
endmodule

// [rtl/adc_result_dac_control.sv]
// Summary of operation
// RULE1: Right-justified: result 9:8 in high 1:0
// RULE2: Right-justified: result 7:0 in low register
// RULE3: Justify select picks layout, zeroes unused bits
// RULE4: Go flag starts conversion, clears when done
// RULE5: Software waits acquisition time before go
// RULE6: DAC enabled only while enable bit set
// RULE7: Eight-bit level code picks one of 256
// RULE8: DAC feeds comparator, ADC channel, pin
// RULE9: Pin enable drives DAC, disables digital buffers
// RULE10: Pin reads zero while carrying DAC voltage
// RULE11: Sleep wake leaves DAC control zero unchanged
// RULE12: Software disables DAC before sleep
// RULE13: Reset disables DAC, clears level code
// RULE14: Source select: supply, ext ref, fixed ref
// RULE15: Result registers hold until next conversion
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "conv_ctrl_params.svh"
module adc_result_dac_control #(
  parameter int CONV_CYCLES = `CONV_CYCLES_DEFAULT
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog converter side
  input wire logic [9:0] conversion_result,
  output logic conv_start,
  // DAC analog controls
  output logic dac_on,
  output logic [7:0] dac_level_code,
  output conv_ctrl_pkg::dac_source_t dac_source_select,
  output logic dac_to_comparator,
  output logic dac_to_adc_channel,
  // DAC output pin
  input wire logic pin_in,
  output logic pin_analog_out,
  output logic pin_digital_off
);
  import conv_ctrl_pkg::*;

  // Counter is 16 bits wide, so longer conversions cannot be timed
  if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) begin : g_bad_cycles
    $error("CONV_CYCLES out of range");
  end

  // ------------------------------
  // Declarations
  // ------------------------------
  logic [7:0] adc_control;
  logic [7:0] adc_format;
  logic [7:0] dac_control_zero;
  logic [7:0] dac_control_one;
  logic pin_sync1;
  logic pin_sync2;
  logic pin_read;
  logic [15:0] conv_count;
  conv_state_t conv_state;
  logic wr;
  logic rd;
  logic mapped;
  logic go_write;
  logic done;
  logic [31:0] next_prdata;
  result_if rif ();

  result_format u_format (
    .pclk(pclk),
    .rif(rif)
  );

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign go_write = wr && paddr == `OFS_ADC_CONTROL &&
    pwdata[`BIT_CONV_GO];
  assign done = conv_state == conv_busy && conv_count == 16'h0000;
  assign rif.load = done;
  assign rif.justify = adc_format[`BIT_JUSTIFY];
  assign rif.conversion_result = conversion_result;

  // ------------------------------
  // APB slave
  // ------------------------------
  // Zero wait states; unmapped addresses error out and read zero
  always_comb begin
    mapped = 1'b1;
    case (paddr)
      `OFS_ADC_CONTROL: next_prdata = {24'h000000, adc_control};
      `OFS_ADC_FORMAT: next_prdata = {24'h000000, adc_format};
      `OFS_RESULT_HIGH: next_prdata = {24'h000000, rif.high};
      `OFS_RESULT_LOW: next_prdata = {24'h000000, rif.low};
      `OFS_DAC_CONTROL_ZERO: next_prdata = {24'h000000, dac_control_zero};
      `OFS_DAC_CONTROL_ONE: next_prdata = {24'h000000, dac_control_one};
      `OFS_PIN_STATUS: next_prdata = {31'h00000000, pin_read};
      default: begin
        next_prdata = 32'h00000000;
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd) begin
      prdata <= next_prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
    end
  end

  // ------------------------------
  // Conversion control
  // ------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_state <= conv_idle;
      conv_count <= 16'h0000;
    end else begin
      case (conv_state)
        conv_idle: begin
          if (go_write) begin
            conv_state <= conv_busy; // RULE4
            conv_count <= 16'(CONV_CYCLES - 1);
          end
        end
        conv_busy: begin
          // A go landing on the completion edge restarts at once
          if (conv_count == 16'h0000) begin
            if (go_write) begin
              conv_count <= 16'(CONV_CYCLES - 1); // RULE4
            end else begin
              conv_state <= conv_idle; // RULE4
            end
          end else begin
            conv_count <= conv_count - 16'h0001;
          end
        end
        default: conv_state <= conv_idle;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= go_write && (conv_state == conv_idle || done); // RULE4
    end
  end

  // Go bit is hardware owned: set by write, cleared on completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_control <= `RST_ADC_CONTROL;
    end else begin
      if (wr && paddr == `OFS_ADC_CONTROL) begin
        adc_control <= pwdata[7:0] & 8'h7D;
      end
      if (go_write || conv_state == conv_busy && !done) begin
        adc_control[`BIT_CONV_GO] <= 1'b1; // RULE4
      end else if (done) begin
        adc_control[`BIT_CONV_GO] <= 1'b0; // RULE4
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_format <= `RST_ADC_FORMAT;
    end else if (wr && paddr == `OFS_ADC_FORMAT) begin
      adc_format <= pwdata[7:0] & 8'h80;
    end
  end

  // ------------------------------
  // DAC control
  // ------------------------------
  // Sleep is not a reset here, so control zero just holds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_control_zero <= `RST_DAC_ZERO; // RULE13
    end else if (wr && paddr == `OFS_DAC_CONTROL_ZERO) begin
      dac_control_zero <= pwdata[7:0] & 8'hAC; // RULE11
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_control_one <= `RST_DAC_ONE; // RULE13
    end else if (wr && paddr == `OFS_DAC_CONTROL_ONE) begin
      dac_control_one <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_on <= 1'b0;
      dac_level_code <= 8'h00;
      dac_source_select <= src_supply;
      dac_to_comparator <= 1'b0;
      dac_to_adc_channel <= 1'b0;
      pin_analog_out <= 1'b0;
      pin_digital_off <= 1'b0;
    end else begin
      dac_on <= dac_control_zero[`BIT_DAC_EN]; // RULE6
      dac_level_code <= dac_control_one; // RULE7
      dac_source_select <= dac_source_t'(
        dac_control_zero[`BIT_PSS_HI:`BIT_PSS_LO]); // RULE14
      dac_to_comparator <= dac_control_zero[`BIT_DAC_EN]; // RULE8
      dac_to_adc_channel <= dac_control_zero[`BIT_DAC_EN]; // RULE8
      pin_analog_out <= dac_control_zero[`BIT_DAC_EN] &&
        dac_control_zero[`BIT_DAC_OE]; // RULE9
      pin_digital_off <= dac_control_zero[`BIT_DAC_OE]; // RULE9
    end
  end

  // ------------------------------
  // Pin read-back
  // ------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync1 <= 1'b0;
      pin_sync2 <= 1'b0;
    end else begin
      pin_sync1 <= pin_in;
      pin_sync2 <= pin_sync1;
    end
  end

  assign pin_read = pin_sync2 && !dac_control_zero[`BIT_DAC_OE]; // RULE10
endmodule

// [tb/conv_ctrl_properties.sv]
`timescale 1ns/1ps
`include "conv_ctrl_params.svh"
module conv_ctrl_checker
  import conv_ctrl_pkg::*;
#(parameter int CONV_CYCLES = 16) (
  input wire logic pclk, presetn, psel, penable, pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic pready, pslverr, conv_start, pin_in,
  input wire logic [9:0] conversion_result,
  input wire logic [7:0] dac_level_code,
  input wire conv_ctrl_pkg::dac_source_t dac_source_select,
  input wire logic dac_on, dac_to_comparator, dac_to_adc_channel,
  input wire logic pin_analog_out, pin_digital_off
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence acc; psel && penable && pready; endsequence
  sequence wr_at(logic [11:0] a); acc ##0 pwrite && paddr == a; endsequence
  a_zero_wait: assert property (psel && !penable |=> pready)
    else $error("no ready in access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_go_starts: assert property (
    wr_at(`OFS_ADC_CONTROL) ##0 pwdata[1] |-> ##[1:2] conv_start)
    else $error("go did not start");
  a_start_single: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  a_level_follow: assert property (
    wr_at(`OFS_DAC_CONTROL_ONE) |-> ##2 dac_level_code == $past(pwdata[7:0], 2))
    else $error("level code wrong");
  a_source_follow: assert property (
    wr_at(`OFS_DAC_CONTROL_ZERO) |-> ##2 dac_on == $past(pwdata[7], 2)
    && dac_source_select == $past(pwdata[3:2], 2))
    else $error("control zero outputs wrong");
  a_dac_fan_out: assert property (
    dac_to_comparator == dac_on && dac_to_adc_channel == dac_on)
    else $error("fan out wrong");
  a_pin_route: assert property (
    pin_analog_out == (dac_on && pin_digital_off))
    else $error("pin route wrong");
  a_pin_reads_zero: assert property (
    acc ##0 !pwrite && paddr == `OFS_PIN_STATUS && pin_digital_off
    |-> prdata == 32'h0) else $error("analog pin read not zero");
  a_reset_clears: assert property (
    $rose(presetn) |-> !dac_on && dac_level_code == 8'h00 && !pin_analog_out)
    else $error("reset left dac active");
endmodule
bind adc_result_dac_control conv_ctrl_checker
  #(.CONV_CYCLES(CONV_CYCLES)) conv_ctrl_checker_inst (.*);

// [tb/tb_top.sv]
`timescale 1ns/1ps
`include "conv_ctrl_params.svh"
module tb_top;
  import conv_ctrl_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic pin_in = 0, pready, pslverr, conv_start, dac_on, pin_analog_out;
  logic dac_to_comparator, dac_to_adc_channel, pin_digital_off;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rs = 32'h00009C2E;
  logic [9:0] conversion_result = 10'h000;
  logic [7:0] dac_level_code;
  dac_source_t dac_source_select;
  logic [32:0] q[$];
  int fails = 0, total_checks = 0;
  always #5 pclk = ~pclk;
  // Short conversion keeps the run brief
  adc_result_dac_control #(.CONV_CYCLES(4)) adc_result_dac_control_inst (.*);
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Read monitor: error flag and data against oldest note
  always @(posedge pclk) if (psel && penable && pready && !pwrite)
    chk({pslverr, prdata}, q.pop_front());
  // Leading edge keeps two calls from driving in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    q.push_back(e);
    apb(0, a, 32'h0);
  endtask
  task automatic rst();
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge pclk);
    fails++;
    end_sim();
  end
  initial begin
    logic [9:0] r;
    logic [31:0] v;
    rst();
    rd(`OFS_DAC_CONTROL_ZERO, 33'h0);
    rd(`OFS_DAC_CONTROL_ONE, 33'h0);
    apb(1, 12'h01C, 32'hFF);
    rd(12'h01C, 33'h1_0000_0000);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 32'hFF : xs() & 32'hFF;
      apb(1, `OFS_DAC_CONTROL_ONE, v);
      rd(`OFS_DAC_CONTROL_ONE, 33'(v));
      chk(33'(dac_level_code), 33'(v));
    end
    for (int s = 0; s < 3; s++) begin
      v = {24'h0, 1'(s != 1), 1'b1, 1'(s != 0), 1'b1, 2'(s), 2'b11};
      apb(1, `OFS_DAC_CONTROL_ZERO, v);
      pin_in <= 1;
      rd(`OFS_DAC_CONTROL_ZERO, 33'(v & 32'hAC));
      chk(33'(dac_source_select), 33'(s));
      chk(33'({dac_on, dac_to_comparator, dac_to_adc_channel}),
        {30'h0, {3{v[7]}}});
      chk(33'({pin_analog_out, pin_digital_off}),
        33'({v[7] & v[5], v[5]}));
      rd(`OFS_PIN_STATUS, 33'(!v[5]));
    end
    for (int j = 0; j < 2; j++) repeat (2) begin
      v = xs();
      r = v[9:0];
      conversion_result <= r;
      apb(1, `OFS_ADC_FORMAT, 32'(j) << 7);
      repeat (4) @(posedge pclk);
      apb(1, `OFS_ADC_CONTROL, 32'h2);
      rd(`OFS_ADC_CONTROL, 33'h2);
      repeat (8) @(posedge pclk);
      rd(`OFS_ADC_CONTROL, 33'h0);
      rd(`OFS_RESULT_HIGH, j ? 33'(r[9:8]) : 33'(r[9:2]));
      rd(`OFS_RESULT_LOW, j ? 33'(r) & 33'hFF : 33'({r[1:0], 6'h0}));
    end
    conversion_result <= ~r;
    rst();
    rd(`OFS_RESULT_HIGH, 33'(r[9:8]));
    rd(`OFS_RESULT_LOW, 33'(r) & 33'hFF);
    chk(33'({dac_on, pin_analog_out, dac_level_code}), 33'h0);
    apb(1, `OFS_DAC_CONTROL_ZERO, 32'h0);
    end_sim();
  end
endmodule
